// >>> design/cpf_consts.svh
// Constants of the coprocessor pipeline follower: handshake codes, instruction fields, resets.
// Assumes it is included by its bare name wherever one of these values is needed.
`ifndef CPF_CONSTS_SVH
`define CPF_CONSTS_SVH

// Handshake codes shared by the decode and execute buses.
`define CPF_HS_WAIT   2'h0
`define CPF_HS_GO     2'h1
`define CPF_HS_ABSENT 2'h2
`define CPF_HS_LAST   2'h3

// Instruction word field positions and group codes.
`define CPF_F_GRP4_LO 24
`define CPF_F_GRP3_LO 25
`define CPF_GRP_REG   4'he
`define CPF_GRP_MEM   3'h6
`define CPF_F_OPB     4
`define CPF_F_LOAD    20
`define CPF_F_CRN_LO  16
`define CPF_F_CRD_LO  12
`define CPF_F_NUM_LO  8
`define CPF_F_CNT_LO  0
`define CPF_F_LEN_LO  5

// Reset and default values; the coprocessor number default is arbitrary.
`define CPF_RST_WORD  32'h0000_0000
`define CPF_DEF_CPNUM 4'ha
`define CPF_DEF_PRIV  4'h8
`define CPF_NREG      16

`endif

// >>> design/cpf_pkg.sv
// Types shared by the coprocessor pipeline follower modules.
// Assumes nothing beyond a SystemVerilog compiler; values live in cpf_consts.svh.
package cpf_pkg;
  // Two-bit handshake code.
  typedef logic [1:0] cpf_hs_t;
  // Instruction class, one-hot.
  typedef enum logic [5:0] {
    CLS_NONE = 6'h01,
    CLS_LDC  = 6'h02,
    CLS_STC  = 6'h04,
    CLS_MCR  = 6'h08,
    CLS_MRC  = 6'h10,
    CLS_CDP  = 6'h20
  } cpf_cls_e;
  // Execute stage state, one-hot.
  typedef enum logic [2:0] {
    EX_IDLE = 3'h1,
    EX_WAIT = 3'h2,
    EX_XFER = 3'h4
  } cpf_ex_e;
endpackage : cpf_pkg

// >>> design/cpf_if.sv
// Interfaces that join the follower to its decoder and its register file.
// Assumes cpf_pkg is compiled first.
`timescale 1ns/1ns
`default_nettype none

interface cpf_dec_if;
  import cpf_pkg::*;
  logic [31:0] word;       // Instruction word to classify.
  logic        own;        // Addressed to this coprocessor.
  logic        restricted; // Needs a privileged mode.
  cpf_cls_e    cls;        // Instruction class.
  logic [3:0]  idx;        // Coprocessor register index.
  logic [2:0]  words;      // Words to move, one to four.
  logic [3:0]  len;        // Internal operation length in cycles.
  modport dec  (input word, output own, restricted, cls, idx, words, len);
  modport user (output word, input own, restricted, cls, idx, words, len);
endinterface : cpf_dec_if

interface cpf_rf_if;
  logic        we;    // Write strobe.
  logic [3:0]  widx;  // Write index.
  logic [31:0] wdata; // Write data.
  logic [3:0]  ridx;  // Read index.
  logic [31:0] rdata; // Read data, combinational.
  modport rf   (input we, widx, wdata, ridx, output rdata);
  modport user (output we, widx, wdata, ridx, input rdata);
endinterface : cpf_rf_if

`default_nettype wire

// >>> design/cpf_decoder.sv
// Combinational classifier of one instruction word for the follower.
// Assumes the word is stable within the cycle; it holds no state.
`timescale 1ns/1ns
`default_nettype none
`include "cpf_consts.svh"

module cpf_decoder
  import cpf_pkg::*;
#(
  parameter logic [3:0] CPNUM      = `CPF_DEF_CPNUM, // Number this coprocessor answers to.
  parameter logic [3:0] PRIV_FIRST = `CPF_DEF_PRIV   // First register kept for privileged use.
) (
  cpf_dec_if.dec d
);

  // Register and memory groups are told apart by the top opcode bits.
  always_comb begin
    d.cls   = CLS_NONE;
    d.idx   = d.word[`CPF_F_CRD_LO +: 4];
    d.words = 3'h1;
    d.len   = {1'b0, d.word[`CPF_F_LEN_LO +: 3]} + 4'h1;
    if (d.word[`CPF_F_GRP4_LO +: 4] == `CPF_GRP_REG) begin
      if (!d.word[`CPF_F_OPB]) begin
        d.cls = CLS_CDP;
      end else begin
        d.idx = d.word[`CPF_F_CRN_LO +: 4];
        d.cls = d.word[`CPF_F_LOAD] ? CLS_MRC : CLS_MCR;
      end
    end else if (d.word[`CPF_F_GRP3_LO +: 3] == `CPF_GRP_MEM) begin
      d.cls   = d.word[`CPF_F_LOAD] ? CLS_LDC : CLS_STC;
      d.words = {1'b0, d.word[`CPF_F_CNT_LO +: 2]} + 3'h1;
    end
    d.own        = (d.cls != CLS_NONE) && (d.word[`CPF_F_NUM_LO +: 4] == CPNUM);
    d.restricted = (d.idx >= PRIV_FIRST);
  end

endmodule : cpf_decoder

`default_nettype wire

// >>> design/cpf_regfile.sv
// Coprocessor register bank in flip-flops, one write and one read port.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "cpf_consts.svh"

module cpf_regfile #(
  parameter int NREG = `CPF_NREG // Number of registers.
) (
  input wire logic sys_clk,
  input wire logic resetn,
  cpf_rf_if.rf     r
);

  typedef struct packed {
    logic [NREG-1:0][31:0] regs; // Register contents.
  } cpf_rf_s;

  cpf_rf_s s;      // Registered bank.
  cpf_rf_s next_s; // Next value of the bank.

  // A write lands on the entry the index picks.
  always_comb begin
    next_s = s;
    if (r.we) begin
      next_s.regs[r.widx] = r.wdata;
    end
  end

  // The whole bank clears at reset.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Reads are combinational so the follower can register them itself.
  assign r.rdata = s.regs[r.ridx];

endmodule : cpf_regfile

`default_nettype wire

// >>> design/cpf_follower.sv
// Coprocessor pipeline follower: tracks the core pipeline and answers its handshakes.
// Assumes every input comes from core logic on sys_clk, so none is synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "cpf_consts.svh"

module cpf_follower
  import cpf_pkg::*;
#(
  parameter logic [3:0] CPNUM      = `CPF_DEF_CPNUM, // Coprocessor number.
  parameter logic [3:0] PRIV_FIRST = `CPF_DEF_PRIV   // First privileged register.
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        follower_clock_enable,
  input  wire logic        pipe_advance_request_n,
  input  wire logic [31:0] issued_instruction_word,
  input  wire logic        condition_pass,
  input  wire logic        late_cancel,
  input  wire logic        privileged_mode_flag,
  input  wire logic [31:0] outgoing_transfer_data,
  output logic      [1:0]  decode_stage_handshake,
  output logic      [1:0]  execute_stage_handshake,
  output logic      [31:0] incoming_transfer_data,
  output logic      [7:0]  ops_completed
);

  // Whole state of the follower.
  typedef struct packed {
    logic [31:0] fetch_word; // Last word sampled from the issue bus.
    logic        fetch_vld;  // Fetch slot holds a real word.
    logic [31:0] dec_word;   // Decode stage word.
    logic        dec_vld;    // Decode stage holds a real word.
    cpf_hs_t     hs_de;      // Decode answer being driven.
    cpf_hs_t     hs_ex;      // Execute answer being driven.
    cpf_ex_e     ex;         // Execute stage state.
    cpf_cls_e    ex_cls;     // Class of the executing instruction.
    logic [1:0]  ex_age;     // Enabled edges since entry, saturating at two.
    logic [2:0]  ex_left;    // Words still to move.
    logic [3:0]  ex_idx;     // Register for the next word.
    logic [3:0]  ex_len;     // Internal operation length.
    logic        rd_vld;     // A read beat waits for its data.
    logic [3:0]  rd_idx;     // Register that beat reads.
    logic [31:0] in_data;    // Data driven towards the core.
    logic        p1_vld;     // Beat one edge old.
    logic        p1_first;   // That beat was made at entry and awaits its pass check.
    cpf_cls_e    p1_cls;
    logic [3:0]  p1_idx;
    logic [3:0]  p1_len;
    logic        p2_vld;     // Beat two edges old, resolved this cycle.
    cpf_cls_e    p2_cls;
    logic [3:0]  p2_idx;
    logic [3:0]  p2_len;
    logic [3:0]  busy_cnt;   // Cycles left of a running internal operation.
    logic [7:0]  ops;        // Completed internal operations.
  } cpf_st_s;

  cpf_st_s     s;           // Registered state.
  cpf_st_s     next_s;      // Next state.
  logic        adv;         // Pipeline advances at this edge.
  logic [31:0] dec_word_nx; // Decode word after this edge.
  logic        dec_vld_nx;  // Decode valid after this edge.
  logic        stepping;    // The execute stage consumes an answer.
  logic        beat;        // One word or operation goes ahead.
  logic        busy_nx;     // Coprocessor busy after this edge.
  cpf_hs_t     resp;        // Answer the core sampled at this edge.

  cpf_dec_if dec_nx ();  // Classifies the next decode word.
  cpf_dec_if dec_cur (); // Classifies the word now entering execute.
  cpf_rf_if  rf ();      // Register bank port.

  cpf_decoder #(.CPNUM(CPNUM), .PRIV_FIRST(PRIV_FIRST)) u_dec_nx  (.d(dec_nx.dec));
  cpf_decoder #(.CPNUM(CPNUM), .PRIV_FIRST(PRIV_FIRST)) u_dec_cur (.d(dec_cur.dec));
  cpf_regfile #(.NREG(`CPF_NREG)) u_rf (.sys_clk(sys_clk), .resetn(resetn), .r(rf.rf));

  // Stages move only when enabled with the request low; an interlock just holds.
  assign adv         = follower_clock_enable && !pipe_advance_request_n;
  assign dec_word_nx = adv ? s.fetch_word : s.dec_word;
  assign dec_vld_nx  = adv ? s.fetch_vld : s.dec_vld;
  assign dec_nx.word  = dec_word_nx;
  assign dec_cur.word = s.dec_word;

  // A matured move or load beat writes unless it was cancelled late.
  assign rf.we    = follower_clock_enable && s.p2_vld && !late_cancel
                    && (s.p2_cls == CLS_MCR || s.p2_cls == CLS_LDC);
  assign rf.widx  = s.p2_idx;
  assign rf.wdata = outgoing_transfer_data;
  assign rf.ridx  = s.rd_idx;

  // Next-state logic for pipeline, execute stage, beats and handshakes.
  always_comb begin
    next_s   = s;
    stepping = 1'b0;
    beat     = 1'b0;
    resp     = `CPF_HS_ABSENT;
    // An internal operation keeps running even while the core is stalled.
    if (s.busy_cnt != 4'h0) begin
      next_s.busy_cnt = s.busy_cnt - 4'h1;
      if (s.busy_cnt == 4'h1) begin
        next_s.ops = s.ops + 8'h01;
      end
    end
    if (follower_clock_enable) begin
      // Beats age by one stage per enabled edge.
      next_s.p2_vld = s.p1_vld;
      next_s.p2_cls = s.p1_cls;
      next_s.p2_idx = s.p1_idx;
      next_s.p2_len = s.p1_len;
      next_s.p1_vld = 1'b0;
      next_s.p1_first = 1'b0;
      // A single-beat entry leaves execute at once, so its pass is checked on the beat.
      if (s.p1_first && !condition_pass) begin
        next_s.p2_vld = 1'b0;
      end
      next_s.rd_vld = 1'b0;
      // Read data goes out one edge after its beat, else zero for wired-OR use.
      next_s.in_data = s.rd_vld ? rf.rdata : `CPF_RST_WORD;
      // A surviving internal operation starts only now.
      if (s.p2_vld && s.p2_cls == CLS_CDP && !late_cancel) begin
        next_s.busy_cnt = s.p2_len;
      end
      if (s.ex != EX_IDLE && s.ex_age == 2'h1 && late_cancel) begin
        // Late cancel drops the instruction and its next beat.
        next_s.ex     = EX_IDLE;
        next_s.p2_vld = 1'b0;
      end else if (s.ex != EX_IDLE && (s.ex_age == 2'h0 || s.ex == EX_WAIT)
                   && !condition_pass) begin
        // Failed condition or interrupt while waiting: abandon, commit nothing.
        next_s.ex     = EX_IDLE;
        next_s.p2_vld = 1'b0;
      end else if (s.ex != EX_IDLE) begin
        // Later cycles answer through the execute bus.
        stepping = 1'b1;
        resp     = s.hs_ex;
        if (s.ex_age != 2'h2) begin
          next_s.ex_age = s.ex_age + 2'h1;
        end
      end
      if (adv) begin
        // Fetch slot to decode, decode to execute, sample the bus.
        next_s.fetch_word = issued_instruction_word;
        next_s.fetch_vld  = 1'b1;
        next_s.dec_word   = s.fetch_word;
        next_s.dec_vld    = s.fetch_vld;
        if (s.dec_vld) begin
          // Only the answer standing at entry counts.
          stepping       = 1'b1;
          resp           = s.hs_de;
          next_s.ex_cls  = dec_cur.cls;
          next_s.ex_idx  = dec_cur.idx;
          next_s.ex_left = dec_cur.words;
          next_s.ex_len  = dec_cur.len;
          next_s.ex_age  = 2'h0;
        end
      end
      if (stepping) begin
        // Each go or last answer moves one word; the count is the code sequence.
        unique case (resp)
          `CPF_HS_WAIT: begin
            next_s.ex = EX_WAIT;
          end
          `CPF_HS_GO: begin
            beat      = 1'b1;
            next_s.ex = EX_XFER;
          end
          `CPF_HS_LAST: begin
            beat      = 1'b1;
            next_s.ex = EX_IDLE;
          end
          `CPF_HS_ABSENT: begin
            next_s.ex = EX_IDLE;
          end
        endcase
      end
      if (beat) begin
        next_s.p1_vld  = 1'b1;
        next_s.p1_first = adv && s.dec_vld;
        next_s.p1_cls  = next_s.ex_cls;
        next_s.p1_idx  = next_s.ex_idx;
        next_s.p1_len  = next_s.ex_len;
        next_s.rd_vld  = (next_s.ex_cls == CLS_MRC) || (next_s.ex_cls == CLS_STC);
        next_s.rd_idx  = next_s.ex_idx;
        next_s.ex_idx  = next_s.ex_idx + 4'h1;
        next_s.ex_left = next_s.ex_left - 3'h1;
      end
    end
    // Busy while an internal operation runs or is still in flight.
    busy_nx = (next_s.busy_cnt != 4'h0)
              || (next_s.p1_vld && next_s.p1_cls == CLS_CDP)
              || (next_s.p2_vld && next_s.p2_cls == CLS_CDP);
    // Execute answer: wait while busy, then go or last by words left.
    unique case (next_s.ex)
      EX_IDLE: begin
        next_s.hs_ex = `CPF_HS_ABSENT;
      end
      EX_WAIT, EX_XFER: begin
        if (next_s.ex == EX_WAIT && busy_nx) begin
          next_s.hs_ex = `CPF_HS_WAIT;
        end else if (next_s.ex_left >= 3'h2) begin
          next_s.hs_ex = `CPF_HS_GO;
        end else begin
          next_s.hs_ex = `CPF_HS_LAST;
        end
      end
    endcase
    // Decode answer, refreshed every cycle so a mode change can alter it.
    if (!dec_vld_nx || !dec_nx.own) begin
      next_s.hs_de = `CPF_HS_ABSENT;
    end else if (dec_nx.restricted && !privileged_mode_flag) begin
      next_s.hs_de = `CPF_HS_ABSENT;
    end else if (busy_nx || next_s.ex != EX_IDLE) begin
      next_s.hs_de = `CPF_HS_WAIT;
    end else if (dec_nx.words >= 3'h2) begin
      next_s.hs_de = `CPF_HS_GO;
    end else begin
      next_s.hs_de = `CPF_HS_LAST;
    end
  end

  // State register; enum fields get legal codes at reset.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s        <= '0;
      s.ex     <= EX_IDLE;
      s.ex_cls <= CLS_NONE;
      s.p1_cls <= CLS_NONE;
      s.p2_cls <= CLS_NONE;
      s.hs_de  <= `CPF_HS_ABSENT;
      s.hs_ex  <= `CPF_HS_ABSENT;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a state flip-flop.
  assign decode_stage_handshake  = s.hs_de;
  assign execute_stage_handshake = s.hs_ex;
  assign incoming_transfer_data  = s.in_data;
  assign ops_completed           = s.ops;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // An instruction entering with a wait answer.
  sequence seq_entry_wait;
    adv && s.dec_vld && s.hs_de == `CPF_HS_WAIT;
  endsequence
  // A waiting instruction meets a low pass at an enabled edge.
  sequence seq_wait_dropped;
    s.ex == EX_WAIT && follower_clock_enable && !condition_pass && !(adv && s.dec_vld);
  endsequence

  a_empty_absent: assert property (!s.dec_vld |-> s.hs_de == `CPF_HS_ABSENT)
    else $error("Empty decode slot must answer absent.");
  a_idle_ex_absent: assert property (s.ex == EX_IDLE |-> s.hs_ex == `CPF_HS_ABSENT)
    else $error("Idle execute stage must answer absent.");
  a_stage_shift: assert property (adv |=> s.dec_word == $past(s.fetch_word)
      && s.fetch_word == $past(issued_instruction_word))
    else $error("Advance did not shift the stages.");
  a_hold_stall: assert property (!adv |=> $stable(s.dec_word) && $stable(s.fetch_word))
    else $error("Stages moved without an advance.");
  a_priv_refuse: assert property ((dec_vld_nx && dec_nx.restricted
      && !privileged_mode_flag) |=> s.hs_de == `CPF_HS_ABSENT)
    else $error("Restricted instruction accepted in user mode.");
  a_words_code: assert property (s.ex == EX_XFER |->
      s.hs_ex == ((s.ex_left >= 3'h2) ? `CPF_HS_GO : `CPF_HS_LAST))
    else $error("Transfer answer does not match words left.");
  a_wait_holds: assert property ((s.ex == EX_WAIT && s.busy_cnt != 4'h0)
      |-> s.hs_ex == `CPF_HS_WAIT)
    else $error("Busy coprocessor did not answer wait.");
  a_wait_abandon: assert property (seq_wait_dropped |=> s.ex == EX_IDLE ##1 !rf.we)
    else $error("Waiting instruction not abandoned.");
  a_entry_wait: assert property (seq_entry_wait |=> s.ex == EX_WAIT
      && s.hs_ex != `CPF_HS_ABSENT)
    else $error("Waited entry did not hold in the execute stage.");
  a_final_last: assert property ((adv && s.dec_vld && s.hs_de == `CPF_HS_LAST)
      |=> s.ex == EX_IDLE && s.p1_vld)
    else $error("Final decode answer was not honoured.");
  a_pass_drop: assert property ((follower_clock_enable && s.p1_first
      && !condition_pass) |=> !s.p2_vld)
    else $error("Entry beat kept after a failed condition.");
  a_cancel_cdp: assert property ((follower_clock_enable && late_cancel && s.p2_vld
      && s.p2_cls == CLS_CDP && s.busy_cnt == 4'h0) |=> s.busy_cnt == 4'h0)
    else $error("Cancelled internal operation still started.");
  a_rd_zero: assert property ((follower_clock_enable && !s.rd_vld) |=>
      incoming_transfer_data == `CPF_RST_WORD)
    else $error("Read bus not idle at zero.");

endmodule : cpf_follower

`default_nettype wire

// >>> design/cpf_follower_end.sv
// Holds no logic; the follower and its helpers live in the other design files.
// Assumes nothing of its surroundings.

// >>> test/cpf_core_model.sv
// Behavioural model of the core that feeds the follower and gathers its answers.
// Assumes one clock; every output changes 1 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
`include "cpf_consts.svh"

module cpf_core_model
  import cpf_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             follower_clock_enable,
  output logic             pipe_advance_request_n,
  output logic      [31:0] issued_instruction_word,
  output logic             condition_pass,
  output logic             late_cancel,
  output logic             privileged_mode_flag,
  output logic      [31:0] outgoing_transfer_data,
  input  wire logic [1:0]  decode_stage_handshake,
  input  wire logic [1:0]  execute_stage_handshake,
  input  wire logic [31:0] incoming_transfer_data
);
  logic [1:0] de_s; // Decode answer standing at the coming edge.
  logic [1:0] ex_s; // Execute answer standing at the coming edge.

  // Quiet values at time zero: no enable and no advance.
  initial begin
    follower_clock_enable = 1'b0;
    pipe_advance_request_n = 1'b1;
    issued_instruction_word = 32'h0;
    condition_pass = 1'b0;
    late_cancel = 1'b0;
    privileged_mode_flag = 1'b0;
    outgoing_transfer_data = 32'h0;
  end

  // One edge; the request acts as a register updated just after each edge.
  task automatic tick(input logic en, input logic adv, input logic [31:0] w);
    follower_clock_enable = en;
    pipe_advance_request_n = ~adv;
    issued_instruction_word = w;
    de_s = decode_stage_handshake;
    ex_s = execute_stage_handshake;
    @(posedge sys_clk);
    #1;
  endtask : tick

  // Fetch, decode and execute one word; each gap step inserts one disabled edge and one interlock edge in decode.
  task automatic run(input logic [31:0] w, input logic priv, input logic pass,
                     input logic cancel, input logic [31:0] d, input int gap,
                     output logic [1:0] de, output int beats, output logic [31:0] rd);
    logic done;
    int   kd;
    privileged_mode_flag = priv;
    tick(1'b1, 1'b1, w);
    tick(1'b1, 1'b1, 32'h0);
    // A foreign word on the bus must never slip in while stalled.
    repeat (gap) begin
      tick(1'b0, 1'b1, 32'hee01_0510);
      tick(1'b1, 1'b0, 32'hee01_0510);
    end
    tick(1'b1, 1'b1, 32'h0);
    de = de_s;
    beats = (de == `CPF_HS_GO || de == `CPF_HS_LAST) ? 1 : 0;
    done = (de == `CPF_HS_LAST || de == `CPF_HS_ABSENT);
    kd = 0;
    rd = 32'h0;
    // Stall the pipe while beats or waits remain, then advance empty words.
    for (int k = 1; k < 14 && !(done && k > kd + 3); k++) begin
      condition_pass = pass && de != `CPF_HS_ABSENT && (!done || k == kd + 1);
      late_cancel = cancel && k == 2;
      outgoing_transfer_data = d + 32'(k);
      if (k == 2) rd = incoming_transfer_data;
      tick(1'b1, done, 32'h0);
      if (!done) begin
        if (!pass) done = 1'b1;
        else if (ex_s == `CPF_HS_GO) beats++;
        else if (ex_s == `CPF_HS_LAST) begin
          beats++;
          done = 1'b1;
        end
        kd = k;
      end
    end
    condition_pass = 1'b0;
    late_cancel = 1'b0;
  endtask : run
endmodule : cpf_core_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench: the core model drives the follower through tabled and hand cases.
// Assumes the follower's default coprocessor number and privileged boundary.
`timescale 1ns/1ns
`default_nettype none
`include "cpf_consts.svh"

module testbench
  import cpf_pkg::*;
();
  // One tabled instruction with the answers it should give.
  typedef struct {
    logic [31:0] w;
    logic        priv;
    logic        pass;
    logic        cancel;
    logic [31:0] d;
    int          gap;
    logic [1:0]  de;
    int          beats;
    logic [31:0] rd;
  } cpf_row_s;

  logic        sys_clk;
  logic        resetn;
  logic        en;
  logic        adv_n;
  logic [31:0] word;
  logic        pass;
  logic        cancel;
  logic        priv;
  logic [31:0] dout;
  logic [1:0]  hs_de;
  logic [1:0]  hs_ex;
  logic [31:0] din;
  logic [7:0]  ops;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // Written data lands two edges after its beat, so a register holds d + 2 onwards.
  cpf_row_s    rows [0:16] = '{
    '{32'hee01_0a10, 1'b0, 1'b1, 1'b0, 32'h1000_0000, 0, 2'h3, 1, 32'h0},
    '{32'hee11_0a10, 1'b0, 1'b1, 1'b0, 32'h0, 0, 2'h3, 1, 32'h1000_0002},
    '{32'hee09_0a10, 1'b0, 1'b1, 1'b0, 32'h2000_0000, 0, 2'h2, 0, 32'h0},
    '{32'hee09_0a10, 1'b1, 1'b1, 1'b0, 32'h3000_0000, 2, 2'h3, 1, 32'h0},
    '{32'hee19_0a10, 1'b1, 1'b1, 1'b0, 32'h0, 0, 2'h3, 1, 32'h3000_0002},
    '{32'hee19_0a10, 1'b0, 1'b1, 1'b0, 32'h0, 0, 2'h2, 0, 32'h0},
    '{32'hee11_0510, 1'b1, 1'b1, 1'b0, 32'h0, 0, 2'h2, 0, 32'h0},
    '{32'he1a0_0000, 1'b1, 1'b1, 1'b0, 32'h0, 0, 2'h2, 0, 32'h0},
    '{32'hec10_2a03, 1'b0, 1'b1, 1'b0, 32'h4000_0000, 0, 2'h1, 4, 32'h0},
    '{32'hee12_0a10, 1'b0, 1'b1, 1'b0, 32'h0, 0, 2'h3, 1, 32'h4000_0002},
    '{32'hee15_0a10, 1'b0, 1'b1, 1'b0, 32'h0, 0, 2'h3, 1, 32'h4000_0005},
    '{32'hec10_6a00, 1'b0, 1'b1, 1'b0, 32'h5000_0000, 0, 2'h3, 1, 32'h0},
    '{32'hee16_0a10, 1'b0, 1'b1, 1'b0, 32'h0, 0, 2'h3, 1, 32'h5000_0002},
    '{32'hee01_0a10, 1'b0, 1'b1, 1'b1, 32'h6000_0000, 0, 2'h3, 1, 32'h0},
    '{32'hee11_0a10, 1'b0, 1'b1, 1'b0, 32'h0, 0, 2'h3, 1, 32'h1000_0002},
    '{32'hee01_0a10, 1'b0, 1'b0, 1'b0, 32'h7000_0000, 0, 2'h3, 1, 32'h0},
    '{32'hee11_0a10, 1'b0, 1'b1, 1'b0, 32'h0, 0, 2'h3, 1, 32'h1000_0002}
  };

  cpf_follower DUT (
    .sys_clk                 (sys_clk),
    .resetn                  (resetn),
    .follower_clock_enable   (en),
    .pipe_advance_request_n  (adv_n),
    .issued_instruction_word (word),
    .condition_pass          (pass),
    .late_cancel             (cancel),
    .privileged_mode_flag    (priv),
    .outgoing_transfer_data  (dout),
    .decode_stage_handshake  (hs_de),
    .execute_stage_handshake (hs_ex),
    .incoming_transfer_data  (din),
    .ops_completed           (ops)
  );

  cpf_core_model core (
    .sys_clk                 (sys_clk),
    .follower_clock_enable   (en),
    .pipe_advance_request_n  (adv_n),
    .issued_instruction_word (word),
    .condition_pass          (pass),
    .late_cancel             (cancel),
    .privileged_mode_flag    (priv),
    .outgoing_transfer_data  (dout),
    .decode_stage_handshake  (hs_de),
    .execute_stage_handshake (hs_ex),
    .incoming_transfer_data  (din)
  );

  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Compares a handshake code.
  task automatic chk_hs(input string nm, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_hs

  // Compares a data word or a count.
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  // Holds reset for four edges, then checks the idle outputs.
  task automatic do_reset;
    resetn = 1'b0;
    repeat (4) core.tick(1'b1, 1'b0, 32'h0);
    resetn = 1'b1;
    chk_hs("reset_de", 2'h2, hs_de);
    chk_hs("reset_ex", 2'h2, hs_ex);
    chk_word("reset_din", 32'h0, din);
    chk_word("reset_ops", 32'h0, {24'h0, ops});
    $display("reset test done");
  endtask : do_reset

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // Cuts a hang short; the whole run needs well under this span.
  initial begin
    #60000;
    n_mismatch++;
    end_sim();
  end

  // Main sequence: table rows first, then operations that overlap or abort.
  initial begin
    logic [1:0]  de;
    int          bt;
    logic [31:0] rd;
    resetn = 1'b0;
    do_reset();
    foreach (rows[i]) begin
      core.run(rows[i].w, rows[i].priv, rows[i].pass, rows[i].cancel, rows[i].d,
               rows[i].gap, de, bt, rd);
      chk_hs("entry_hs", rows[i].de, de);
      chk_word("beats", 32'(rows[i].beats), 32'(bt));
      chk_word("read_data", rows[i].rd, rd);
      $display("row %0d done", i);
    end
    core.run(32'hee00_0a00, 1'b0, 1'b1, 1'b1, 32'h0, 0, de, bt, rd);
    repeat (4) core.tick(1'b1, 1'b1, 32'h0);
    chk_word("ops_cancel", 32'h0, {24'h0, ops});
    $display("cancelled operation test done");
    core.run(32'hee00_0ae0, 1'b0, 1'b1, 1'b0, 32'h0, 0, de, bt, rd);
    core.run(32'hee00_0a00, 1'b0, 1'b1, 1'b0, 32'h0, 0, de, bt, rd);
    chk_hs("queued_hs", 2'h0, de);
    chk_word("queued_beats", 32'h1, 32'(bt));
    repeat (12) core.tick(1'b1, 1'b1, 32'h0);
    chk_word("ops_two", 32'h2, {24'h0, ops});
    $display("queued operation test done");
    core.run(32'hee00_0ae0, 1'b0, 1'b1, 1'b0, 32'h0, 0, de, bt, rd);
    core.run(32'hee00_0a00, 1'b0, 1'b0, 1'b0, 32'h0, 0, de, bt, rd);
    chk_hs("abandon_hs", 2'h0, de);
    repeat (12) core.tick(1'b1, 1'b1, 32'h0);
    chk_word("ops_abandon", 32'h3, {24'h0, ops});
    $display("abandoned operation test done");
    do_reset();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
